// *** bbs_top.sv ***
// Burst sequencing, sync master/slave and slope routing for a phase-shifted full bridge
//
// Functional notes
// - Demand below minimum pulse enters burst
// - Bursts deliver only even cycle counts
// - Burst ends on leg1 lower, leg2 upper
// - Stop after burst until demand recovers
// - Master drives half-duty sync at oscillator rate
// - Ground strap makes slave, no sync drive
// - Slave switches 90 degrees after master
// - Oscillator twice switching rate, period equals pulses
// - Slope strap selects peak-current or voltage mode
// - Ramp to limit always, PWM only peak
// - Pulse measured between diagonal edges
// - Off time after burst set by demand
// - Slave aligns oscillator to sync falling edge
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "bbs_regs.svh"
module bbs_top
  import bbs_pkg::*;
#(
  parameter int PW = 16
) (
  input wire logic core_clk, // 10 MHz clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic freq_set_strap, // High: tied to ref supply
  input wire logic slope_set_strap, // High: tied to ref supply
  input wire logic sync_in, // Sync line level
  output logic sync_out, // Sync drive value
  output logic sync_oe_n, // Sync enable, low drives
  output bbs_drive_t drive, // Bridge gate drives
  output bbs_route_t route, // Ramp routing selects
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr // APB error
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    // Input synchronisers
    logic [2:0] fs_sync;
    logic [2:0] ss_sync;
    logic [2:0] sy_sync;

    // Latched straps and software settings
    logic strap_done;
    logic master;
    logic pcm;
    logic en;
    logic [PW-1:0] half;
    logic [PW-1:0] minpw;
    logic [PW-1:0] demand;
    logic [7:0] burst_len;

    // Oscillator and burst sequencer
    logic [PW-1:0] osc_cnt;
    logic osc_ph;
    logic leg;
    logic [PW-1:0] per_cnt;
    logic [7:0] pulses;
    logic [PW-1:0] pulse_w;
    bbs_mode_t mode;

    // Registered outputs
    logic sync_o;
    logic sync_oen;
    bbs_drive_t drv;
    bbs_route_t rt;
    bbs_apb_rsp_t apb;
  } bbs_state_t;

  bbs_state_t st_q, st_d;

  function automatic logic [31:0] bbs_zext(input logic [PW-1:0] v);
    bbs_zext = {{(32-PW){1'b0}}, v};
  endfunction

  // Pulse window: true while the period counter is inside the width
  function automatic logic bbs_on(input logic [PW-1:0] cnt, input logic [PW-1:0] wid);
    bbs_on = cnt < wid;
  endfunction

  // Width actually issued: never shorter than the minimum pulse
  function automatic logic [PW-1:0] bbs_width(input logic [PW-1:0] dem, input logic [PW-1:0] mn);
    bbs_width = (dem < mn) ? mn : dem;
  endfunction

  // Oscillator half count; below two the sync high time, half >> 1, would be zero
  function automatic logic [PW-1:0] bbs_clamp_half(input logic [PW-1:0] v);
    bbs_clamp_half = (v < PW'(2)) ? PW'(2) : v;
  endfunction

  // Burst length rounded down to even, zero lifted to two
  function automatic logic [7:0] bbs_even(input logic [7:0] v);
    bbs_even = (v[7:1] == 7'h00) ? 8'h02 : {v[7:1], 1'b0};
  endfunction

  // ----------------------------------------------------------------
  // Decoded conditions
  // ----------------------------------------------------------------
  logic sync_fall;
  logic period_tick;
  logic osc_tick;
  logic want_short;
  logic [PW-1:0] width;

  logic strap_ready;
  logic pulse_on;
  logic apb_access;
  logic burst_last;
  logic drive_off;

  // Only stages two and three are examined; stage one stays isolated
  assign sync_fall = st_q.sy_sync[2] & ~st_q.sy_sync[1];
  assign osc_tick = (st_q.osc_cnt >= st_q.half - 1'b1) || (!st_q.master && sync_fall);
  assign period_tick = osc_tick && st_q.osc_ph;
  assign want_short = st_q.demand < st_q.minpw;

  assign strap_ready = !st_q.strap_done && (st_q.fs_sync[2] == st_q.fs_sync[1]);
  assign pulse_on = bbs_on(st_q.per_cnt, st_q.pulse_w);
  assign apb_access = psel && penable && !st_q.apb.pready;
  assign burst_last = st_q.leg && (st_q.pulses + 8'h01 >= st_q.burst_len);
  assign drive_off = !st_q.en || !st_q.strap_done || (st_q.mode == BBS_IDLE);

  always_comb begin
    st_d = st_q;
    width = bbs_width(st_q.demand, st_q.minpw);
    st_d.fs_sync = {st_q.fs_sync[1:0], freq_set_strap};
    st_d.ss_sync = {st_q.ss_sync[1:0], slope_set_strap};
    st_d.sy_sync = {st_q.sy_sync[1:0], sync_in};
    st_d.apb.pready = 1'b0;
    st_d.apb.pslverr = 1'b0;

    // ----------------------------------------------------------------
    // Straps latched once after reset, from synchronised levels
    // ----------------------------------------------------------------
    if (strap_ready) begin
      st_d.strap_done = 1'b1;
      st_d.master = st_q.fs_sync[2];
      st_d.pcm = ~st_q.ss_sync[2];
    end

    // Routing held off until the straps are latched, so no selector
    // shows a mode that the straps never asked for
    if (st_q.strap_done) begin
      st_d.rt.pwm_ramp_sel = st_q.pcm;
      st_d.rt.limit_ramp_sel = 1'b1;
      st_d.rt.internal_ramp_sel = ~st_q.pcm;
    end else begin
      st_d.rt = '0;
    end

    // ----------------------------------------------------------------
    // Oscillator at twice the switching rate
    // ----------------------------------------------------------------
    if (osc_tick) begin
      st_d.osc_cnt = '0;
      st_d.osc_ph = ~st_q.osc_ph;
    end else begin
      st_d.osc_cnt = st_q.osc_cnt + 1'b1;
    end
    // Slave restarts at the falling edge: a quarter period behind the master,
    // since its oscillator runs at twice the switching rate
    if (!st_q.master && sync_fall) begin
      st_d.osc_cnt = '0;
    end

    // ----------------------------------------------------------------
    // Sync drive
    // ----------------------------------------------------------------
    // High in the first half of each oscillator cycle
    if (st_q.master && st_q.strap_done) begin
      st_d.sync_oen = 1'b0;
      st_d.sync_o = (st_q.osc_cnt < (st_q.half >> 1));
    end else begin
      st_d.sync_oen = 1'b1;
      st_d.sync_o = 1'b0;
    end

    // ----------------------------------------------------------------
    // Burst sequencer, decisions only at period boundaries
    // ----------------------------------------------------------------
    if (period_tick) begin
      st_d.leg = ~st_q.leg;
      st_d.per_cnt = '0;
      case (st_q.mode)
        BBS_RUN: begin
          if (want_short) begin
            st_d.mode = BBS_BURST;
            st_d.pulses = '0;
            st_d.leg = 1'b0;
          end
          st_d.pulses = '0;
        end

        BBS_BURST: begin
          st_d.pulses = st_q.pulses + 8'h01;
          // Leg 1 means the second diagonal just fired
          if (burst_last) begin
            st_d.mode = want_short ? BBS_IDLE : BBS_RUN;
            st_d.leg = 1'b0;
          end
        end

        BBS_IDLE: begin
          st_d.leg = 1'b0;
          if (!want_short) begin
            st_d.mode = BBS_RUN;
          end
        end

        default: begin
          st_d.mode = BBS_RUN;
        end
      endcase
      st_d.pulse_w = width;
    end else begin
      st_d.per_cnt = st_q.per_cnt + 1'b1;
    end

    // ----------------------------------------------------------------
    // Bridge drives
    // ----------------------------------------------------------------
    // Pulse spans first-side rise to diagonal fall; both switches of a
    // diagonal share one window so the measured width is exact
    st_d.drv = '0;
    if (!drive_off) begin
      if (!st_q.leg) begin
        st_d.drv.leg1_upper_drive = pulse_on;
        st_d.drv.leg2_lower_drive = pulse_on;
      end else begin
        st_d.drv.leg1_lower_drive = pulse_on;
        st_d.drv.leg2_upper_drive = pulse_on;
      end
    end

    // ----------------------------------------------------------------
    // APB slave, one wait state
    // ----------------------------------------------------------------
    // Ready high blocks a second take of the same transfer
    // while the master is still releasing it
    if (apb_access) begin
      st_d.apb.pready = 1'b1;
      st_d.apb.prdata = '0;
      case (paddr)
        `BBS_CTRL_OFS: begin
          st_d.apb.prdata = {31'h0000_0000, st_q.en};
          if (pwrite) begin
            st_d.en = pwdata[`BBS_CTRL_EN_BIT];
          end
        end

        `BBS_PERIOD_OFS: begin
          st_d.apb.prdata = bbs_zext(st_q.half);
          if (pwrite) begin
            st_d.half = bbs_clamp_half(pwdata[PW-1:0]);
          end
        end

        `BBS_MINPW_OFS: begin
          st_d.apb.prdata = bbs_zext(st_q.minpw);
          if (pwrite) begin
            st_d.minpw = pwdata[PW-1:0];
          end
        end

        `BBS_DEMAND_OFS: begin
          st_d.apb.prdata = bbs_zext(st_q.demand);
          if (pwrite) begin
            st_d.demand = pwdata[PW-1:0];
          end
        end

        `BBS_BURST_OFS: begin
          st_d.apb.prdata = {24'h00_0000, st_q.burst_len};
          // Forced even and nonzero so bursts stay balanced
          if (pwrite) begin
            st_d.burst_len = bbs_even(pwdata[7:0]);
          end
        end

        `BBS_STATUS_OFS: begin
          st_d.apb.prdata = {27'h000_0000, st_q.leg, st_q.mode == BBS_IDLE,
                             st_q.mode == BBS_BURST, st_q.pcm, st_q.master};
          st_d.apb.pslverr = pwrite;
        end

        default: begin
          st_d.apb.pslverr = 1'b1;
        end
      endcase
    end

    if (sys_rst) begin
      st_d = '0;
      // Synchronisers keep filling in reset so the straps are valid at release
      st_d.fs_sync = {st_q.fs_sync[1:0], freq_set_strap};
      st_d.ss_sync = {st_q.ss_sync[1:0], slope_set_strap};
      st_d.sy_sync = {st_q.sy_sync[1:0], sync_in};
      st_d.sync_oen = 1'b1;
      st_d.half = `BBS_PERIOD_RST;
      st_d.minpw = `BBS_MINPW_RST;
      st_d.demand = `BBS_DEMAND_RST;
      st_d.burst_len = `BBS_BURST_RST;
      st_d.mode = BBS_RUN;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset is folded into the next-state logic, so one plain flop bank
  always_ff @(posedge core_clk) begin
    st_q <= st_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a field of the state register
  assign sync_out = st_q.sync_o;
  assign sync_oe_n = st_q.sync_oen;
  assign drive = st_q.drv;
  assign route = st_q.rt;
  assign prdata = st_q.apb.prdata;
  assign pready = st_q.apb.pready;
  assign pslverr = st_q.apb.pslverr;

endmodule

// *** bbs_regs.svh ***
// Register offsets, field positions, reset values and timing counts for the bridge burst controller
`ifndef BBS_REGS_SVH
`define BBS_REGS_SVH
`define BBS_CTRL_OFS 12'h000
`define BBS_PERIOD_OFS 12'h004
`define BBS_MINPW_OFS 12'h008
`define BBS_DEMAND_OFS 12'h00C
`define BBS_STATUS_OFS 12'h010
`define BBS_BURST_OFS 12'h014
`define BBS_CTRL_EN_BIT 0
`define BBS_PERIOD_RST 16'h0032
`define BBS_MINPW_RST 16'h0005
`define BBS_DEMAND_RST 16'h0000
`define BBS_ST_MASTER_BIT 0
`define BBS_ST_PCM_BIT 1
`define BBS_ST_BURST_BIT 2
`define BBS_ST_IDLE_BIT 3
`define BBS_ST_LEG_BIT 4
`define BBS_BURST_RST 8'h02
`endif

// *** bbs_pkg.sv ***
// Types shared by the bridge burst controller
package bbs_pkg;
  typedef enum logic [1:0] {
    BBS_RUN = 2'b00,
    BBS_BURST = 2'b01,
    BBS_IDLE = 2'b10
  } bbs_mode_t;
  typedef struct packed {
    logic leg1_upper_drive;
    logic leg1_lower_drive;
    logic leg2_upper_drive;
    logic leg2_lower_drive;
  } bbs_drive_t;
  typedef struct packed {
    logic pwm_ramp_sel;
    logic limit_ramp_sel;
    logic internal_ramp_sel;
  } bbs_route_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } bbs_apb_rsp_t;
endpackage

// *** bbs_top_props.sv ***
// Port checks for the bridge burst controller
`timescale 1ns/100ps
module bbs_top_props
  import bbs_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic freq_set_strap, // Role strap
  input wire logic slope_set_strap, // Mode strap
  input wire logic sync_oe_n, // Sync enable
  input wire bbs_drive_t drive, // Gate drives
  input wire bbs_route_t route, // Ramp routing
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pready, // APB ready
  input wire logic pslverr // APB error
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------
  // Checks
  // ------------------------------------------
  pcm_select_a: assert property ($rose(route.pwm_ramp_sel) |-> !slope_set_strap)
    else $error("pwm ramp with voltage strap");
  vmc_select_a: assert property ($rose(route.internal_ramp_sel) |-> slope_set_strap)
    else $error("internal ramp with current strap");
  limit_ramp_a: assert property (route.pwm_ramp_sel |-> route.limit_ramp_sel)
    else $error("limit ramp missing");
  diag_pair_a: assert property (drive.leg1_upper_drive == drive.leg2_lower_drive)
    else $error("first diagonal split");
  diag_excl_a: assert property (!(drive.leg1_upper_drive && drive.leg1_lower_drive))
    else $error("both diagonals on");
  slave_quiet_a: assert property (!sync_oe_n |-> freq_set_strap)
    else $error("slave drives sync");
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than a cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule
bind bbs_top bbs_top_props bbs_top_props_inst(.core_clk, .sys_rst, .freq_set_strap, .slope_set_strap,
  .sync_oe_n, .drive, .route, .psel, .penable, .pready, .pslverr);

// *** bbs_sync_partner.sv ***
// Second controller acting as sync master
`timescale 1ns/100ps
module bbs_sync_partner (
  input wire logic en, // Partner active
  output logic p_sync, // Sync drive value
  output logic p_oe_n // Sync enable, low drives
);
  logic lclk = 1'b0;
  // Stands still while released
  always begin
    #400;
    lclk = en ? !lclk : 1'b0;
  end
  assign p_sync = lclk;
  assign p_oe_n = !en;
endmodule

// *** bbs_top_test.sv ***
// Self-checking bench for the bridge burst controller
`timescale 1ns/100ps
module bbs_top_test;
  import bbs_pkg::*;
  logic core_clk = 1'b0, sys_rst = 1'b1, freq_set_strap = 1'b1, slope_set_strap = 1'b0, en = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, on_q = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic sync_in, sync_out, sync_oe_n, pready, pslverr, p_sync, p_oe_n, er;
  bbs_drive_t drive;
  bbs_route_t route;
  int bad_count = 0, comparisons = 0, cyc = 0, np = 0, wid = 0, lastw = 0, lastleg = 0;
  int rise_t = 0, intv = 0, shi = 0, hiw = 0, slo = 0, low = 0;
  always #50 core_clk = !core_clk;
  // Pull-up when nobody drives
  assign sync_in = !sync_oe_n ? sync_out : (!p_oe_n ? p_sync : 1'b1);
  bbs_top bbs_top_inst(.core_clk, .sys_rst, .freq_set_strap, .slope_set_strap, .sync_in, .sync_out,
    .sync_oe_n, .drive, .route, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  bbs_sync_partner bbs_sync_partner_inst(.en, .p_sync, .p_oe_n);
  // ------------------------------------------
  // Pulse and sync monitor
  // ------------------------------------------
  always @(posedge core_clk) begin
    cyc++;
    if (drive.leg1_upper_drive || drive.leg1_lower_drive) begin
      if (!on_q) begin
        np++;
        intv = cyc - rise_t;
        rise_t = cyc;
        lastleg = drive.leg1_lower_drive;
        wid = 0;
      end
      wid++;
    end else if (on_q) lastw = wid;
    on_q = drive.leg1_upper_drive || drive.leg1_lower_drive;
    if (sync_out) begin
      shi++;
      if (slo) low = slo;
      slo = 0;
    end else begin
      slo++;
      if (shi) hiw = shi;
      shi = 0;
    end
  end
  // ------------------------------------------
  // Tasks
  // ------------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      bad_count++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic boot(input logic m, input logic s);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    freq_set_strap <= m;
    slope_set_strap <= s;
    en <= !m;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (10) @(posedge core_clk);
  endtask
  // ------------------------------------------
  // Tests
  // ------------------------------------------
  initial begin
    boot(1'b1, 1'b0);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("period", 32'h0000_0032, rd);
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk("burst", 32'h0000_0002, rd);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("status", 32'h0000_0003, rd & 32'h0000_0003);
    chk("route", 32'h0000_0006, route);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, er);
    apb(1'b1, 12'h010, 32'h0000_00ff);
    chk("ro", 32'h0000_0001, er);
    apb(1'b1, 12'h004, 32'h0000_0008);
    apb(1'b1, 12'h00C, 32'h0000_000A);
    apb(1'b1, 12'h000, 32'h0000_0001);
    repeat (100) @(posedge core_clk);
    chk("width", 32'h0000_000A, lastw);
    chk("interval", 32'h0000_0010, intv);
    chk("sync_hi", 32'h0000_0004, hiw);
    chk("sync_lo", 32'h0000_0004, low);
    chk("sync_oe_n", 32'h0000_0000, sync_oe_n);
    $display("master test done");
    apb(1'b1, 12'h014, 32'h0000_0004);
    apb(1'b1, 12'h00C, 32'h0000_0003);
    np = 0;
    repeat (300) @(posedge core_clk);
    chk("pulses", 32'h0000_0004, np);
    chk("last_leg", 32'h0000_0001, lastleg);
    chk("burst_w", 32'h0000_0005, lastw);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("idle", 32'h0000_0008, rd & 32'h0000_0008);
    np = 0;
    apb(1'b1, 12'h00C, 32'h0000_000A);
    repeat (100) @(posedge core_clk);
    chk("resume", 32'h0000_0001, np >= 4);
    chk("resume_w", 32'h0000_000A, lastw);
    $display("burst test done");
    boot(1'b0, 1'b1);
    apb(1'b1, 12'h004, 32'h0000_000A);
    apb(1'b1, 12'h00C, 32'h0000_000A);
    apb(1'b1, 12'h000, 32'h0000_0001);
    repeat (200) @(posedge core_clk);
    chk("slave_oe_n", 32'h0000_0001, sync_oe_n);
    chk("slave_route", 32'h0000_0003, route);
    chk("slave_intv", 32'h0000_0010, intv);
    $display("slave test done");
    results();
  end
endmodule
